// file: hw/ssm_pkg.sv
// Constants, encodings and register map of the storage-mode controller.
package ssm_pkg;

  // ==========================================================================
  // Timing
  localparam longint unsigned CLK_HZ = 64'd100000000;
  localparam int unsigned CLK_KHZ = 32'd100000;
  localparam longint unsigned DAY_S = 64'd86400;
  localparam longint unsigned DAY_CYC = DAY_S * CLK_HZ;
  localparam int unsigned FOB_WINDOW_MS = 32'd1500;
  localparam int unsigned FOB_WINDOW_CYC = FOB_WINDOW_MS * CLK_KHZ;
  localparam int unsigned FOB_HOLD_MS = 32'd1000;
  localparam int unsigned FOB_HOLD_CYC = FOB_HOLD_MS * CLK_KHZ;
  localparam int unsigned FLASH_HALF_MS = 32'd250;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned LAMP_HALF_MS = 32'd500;
  localparam int unsigned LAMP_HALF_CYC = LAMP_HALF_MS * CLK_KHZ;

  // ==========================================================================
  // Storage period selection
  localparam logic [1:0] PER_10 = 2'h0;
  localparam logic [1:0] PER_20 = 2'h1;
  localparam logic [1:0] PER_60 = 2'h2;
  localparam logic [1:0] PER_INF = 2'h3;
  localparam logic [1:0] PER_RESET = PER_10;
  localparam logic [6:0] DAYS_10 = 7'h0a;
  localparam logic [6:0] DAYS_20 = 7'h14;
  localparam logic [6:0] DAYS_60 = 7'h3c;
  localparam logic [6:0] DAYS_MAX = 7'h7f;

  // ==========================================================================
  // Entry sequence counts
  localparam logic [2:0] KEY_EDGES_ENTRY = 3'h4;
  localparam logic [1:0] LEFT_PRESSES_ENTRY = 2'h2;
  localparam logic [2:0] FLASH_ENTRY = 3'h2;
  localparam logic [1:0] FOB_HOLDS = 2'h3;

  // ==========================================================================
  // Configuration state machine
  typedef enum logic [2:0] {
    CFG_IDLE = 3'b000,
    CFG_KEYS = 3'b001,
    CFG_LEFT = 3'b010,
    CFG_FOB = 3'b011,
    CFG_MENU = 3'b100
  } ssm_cfg_t;

  // ==========================================================================
  // Register map (AHB-Lite, one word each)
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam int ADDR_W = 8;

  localparam int ST_STORAGE = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_MENU = 3;
  localparam int ST_FRESH = 4;
  localparam int ST_DAYS_LO = 8;
  localparam int ST_DAYS_HI = 14;

  localparam int IRQ_W = 4;
  localparam int IRQ_STORE_IN = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_ALARM = 2;
  localparam int IRQ_SAVED = 3;

  localparam int CMD_ARM = 0;
  localparam int CMD_DISARM = 1;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

endpackage : ssm_pkg

// file: hw/ssm_flasher.sv
// Counted flash generator for the turn signals and indicators.
`timescale 1ns/1ps
module ssm_flasher #(
  parameter int unsigned HALF_CYC = ssm_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic start,
  input wire logic [2:0] count,
  // Lamp drive
  output logic flash,
  output logic busy
);

  // A new start while busy restarts the sequence, so the latest
  // confirmation always shows in full.
  logic [31:0] timer;
  logic [2:0] remain;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      timer <= 32'h0;
      remain <= 3'h0;
      flash <= 1'b0;
      busy <= 1'b0;
    end
    else if (start && count != 3'h0)
    begin
      timer <= 32'h0;
      remain <= count;
      flash <= 1'b1;
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (timer == HALF_CYC - 32'h1)
      begin
        timer <= 32'h0;
        if (flash)
        begin
          flash <= 1'b0;
          remain <= remain - 3'h1;
        end
        else if (remain != 3'h0)
          flash <= 1'b1;
        else
          busy <= 1'b0;
      end
      else
        timer <= timer + 32'h1;
    end
  end

endmodule : ssm_flasher

// file: hw/ssm_ctrl.sv
// Storage-mode and preference controller with AHB-Lite register slave.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module ssm_ctrl #(
  parameter longint unsigned DAY_CYCLES = ssm_pkg::DAY_CYC,
  parameter int unsigned WINDOW_CYCLES = ssm_pkg::FOB_WINDOW_CYC,
  parameter int unsigned HOLD_CYCLES = ssm_pkg::FOB_HOLD_CYC,
  parameter int unsigned FLASH_CYCLES = ssm_pkg::FLASH_HALF_CYC,
  parameter int unsigned LAMP_CYCLES = ssm_pkg::LAMP_HALF_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ssm_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  // Rider controls
  input wire logic key_switch,
  input wire logic stop_switch_off,
  input wire logic left_turn,
  input wire logic fob_button,
  input wire logic intrusion,
  // Vehicle outputs
  output logic turn_flash,
  output logic security_lamp,
  output logic alarm,
  output logic receiver_en,
  output logic starter_en,
  output logic engine_controller_en
);
  import ssm_pkg::*;

  // ==========================================================================
  // Bus slave
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic addr_ok;
  logic [1:0] period_sel;
  logic storage, armed, power_fresh;
  logic [6:0] days;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set;
  ssm_cfg_t cfg;
  logic [31:0] next_rdata;

  assign addr_ok = hsel && hready && htrans[1];

  always_comb
  begin
    next_rdata = 32'h0;
    unique case (haddr)
      REG_CONFIG: next_rdata[1:0] = period_sel;
      REG_STATUS:
      begin
        next_rdata[ST_STORAGE] = storage;
        next_rdata[ST_ARMED] = armed;
        next_rdata[ST_ALARM] = alarm;
        next_rdata[ST_MENU] = (cfg == CFG_MENU);
        next_rdata[ST_FRESH] = power_fresh;
        next_rdata[ST_DAYS_HI:ST_DAYS_LO] = days;
      end
      REG_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      REG_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      default: next_rdata = 32'h0;
    endcase
  end

  // Zero wait states: read data is prepared in the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr <= haddr;
      if (addr_ok && !hwrite)
        hrdata <= next_rdata;
    end
  end

  logic wr_config, wr_irq_stat, wr_irq_mask, cmd_arm, cmd_disarm;
  assign wr_config = wr_pend && wr_addr == REG_CONFIG;
  assign wr_irq_stat = wr_pend && wr_addr == REG_IRQ_STAT;
  assign wr_irq_mask = wr_pend && wr_addr == REG_IRQ_MASK;
  assign cmd_arm = wr_pend && wr_addr == REG_CMD && hwdata[CMD_ARM];
  assign cmd_disarm = wr_pend && wr_addr == REG_CMD && hwdata[CMD_DISARM];

  // A status bit raised in the same cycle as its clear stays set.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat <= (irq_stat & ~(wr_irq_stat ? hwdata[IRQ_W-1:0] : '0))
        | irq_set;
      if (wr_irq_mask)
        irq_mask <= hwdata[IRQ_W-1:0];
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // Input edges
  logic key_q, left_q, fob_q;
  logic key_edge, key_on, left_rise, fob_rise;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_q <= 1'b0;
      left_q <= 1'b0;
      fob_q <= 1'b0;
    end
    else
    begin
      key_q <= key_switch;
      left_q <= left_turn;
      fob_q <= fob_button;
    end
  end

  assign key_edge = key_switch ^ key_q;
  assign key_on = key_switch && !key_q;
  assign left_rise = left_turn && !left_q;
  // The receiver is shut down in storage, so the fob is not heard.
  assign fob_rise = fob_button && !fob_q && !storage;

  // ==========================================================================
  // Idle day counter and storage state
  logic [63:0] day_tick;
  logic [6:0] limit;
  logic enter_storage, wake;

  always_comb
  begin
    unique case (period_sel)
      PER_10: limit = DAYS_10;
      PER_20: limit = DAYS_20;
      PER_60: limit = DAYS_60;
      PER_INF: limit = DAYS_MAX;
    endcase
  end

  // Armed state plays no part in entry.
  assign enter_storage = !storage && period_sel != PER_INF
    && days >= limit && !key_edge;
  assign wake = storage && key_on;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      day_tick <= 64'h0;
      days <= 7'h0;
    end
    else if (key_edge)
    begin
      day_tick <= 64'h0;
      days <= 7'h0;
    end
    else if (!storage)
    begin
      if (day_tick == DAY_CYCLES - 64'h1)
      begin
        day_tick <= 64'h0;
        if (days != DAYS_MAX)
          days <= days + 7'h1;
      end
      else
        day_tick <= day_tick + 64'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      storage <= 1'b0;
    else if (wake)
      storage <= 1'b0;
    else if (enter_storage)
      storage <= 1'b1;
  end

  // ==========================================================================
  // Fob double press disarm
  logic [31:0] win_cnt;
  logic win_open, fob_disarm;

  assign fob_disarm = fob_rise && win_open;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_cnt <= 32'h0;
      win_open <= 1'b0;
    end
    else if (fob_rise)
    begin
      win_open <= !win_open;
      win_cnt <= 32'h0;
    end
    else if (win_open)
    begin
      if (win_cnt == WINDOW_CYCLES - 32'h1)
        win_open <= 1'b0;
      else
        win_cnt <= win_cnt + 32'h1;
    end
  end

  // ==========================================================================
  // Arming and alarm
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      armed <= 1'b0;
      alarm <= 1'b0;
    end
    else if (fob_disarm || cmd_disarm)
    begin
      armed <= 1'b0;
      alarm <= 1'b0;
    end
    else
    begin
      if (cmd_arm)
        armed <= 1'b1;
      // Intrusion is still watched in storage.
      if ((wake || intrusion) && armed)
        alarm <= 1'b1;
    end
  end

  // ==========================================================================
  // Preference entry sequence and menu
  logic [2:0] key_cnt;
  logic [1:0] press_cnt;
  logic [31:0] hold_cnt;
  logic held;
  logic fl_start;
  logic [2:0] fl_count;
  logic store_sel;
  logic [1:0] menu_sel;
  logic menu_shown;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg <= CFG_IDLE;
      key_cnt <= 3'h0;
      press_cnt <= 2'h0;
      hold_cnt <= 32'h0;
      held <= 1'b0;
      fl_start <= 1'b0;
      fl_count <= 3'h0;
      store_sel <= 1'b0;
      menu_sel <= PER_RESET;
      menu_shown <= 1'b0;
      power_fresh <= 1'b1;
    end
    else
    begin
      fl_start <= 1'b0;
      store_sel <= 1'b0;
      unique case (cfg)
        CFG_IDLE:
        begin
          key_cnt <= 3'h0;
          press_cnt <= 2'h0;
          if (key_on && stop_switch_off && !armed && !storage)
            cfg <= CFG_KEYS;
        end
        CFG_KEYS:
        begin
          if (!stop_switch_off || armed)
            cfg <= CFG_IDLE;
          else if (left_rise)
            cfg <= (key_cnt == KEY_EDGES_ENTRY && key_switch)
              ? CFG_LEFT : CFG_IDLE;
          else if (key_edge)
          begin
            if (key_cnt == KEY_EDGES_ENTRY)
              cfg <= CFG_IDLE;
            else
              key_cnt <= key_cnt + 3'h1;
          end
          if (left_rise && key_cnt == KEY_EDGES_ENTRY && key_switch)
            press_cnt <= 2'h1;
        end
        CFG_LEFT:
        begin
          if (key_edge || !stop_switch_off)
            cfg <= CFG_IDLE;
          else if (left_rise)
          begin
            if (power_fresh)
            begin
              power_fresh <= 1'b0;
              cfg <= CFG_IDLE;
            end
            else if (press_cnt + 2'h1 == LEFT_PRESSES_ENTRY)
            begin
              fl_start <= 1'b1;
              fl_count <= FLASH_ENTRY;
              press_cnt <= 2'h0;
              hold_cnt <= 32'h0;
              held <= 1'b0;
              cfg <= CFG_FOB;
            end
          end
        end
        CFG_FOB:
        begin
          if (key_edge)
            cfg <= CFG_IDLE;
          else if (!fob_button)
          begin
            hold_cnt <= 32'h0;
            held <= 1'b0;
          end
          else if (!held)
          begin
            if (hold_cnt == HOLD_CYCLES - 32'h1)
            begin
              held <= 1'b1;
              press_cnt <= press_cnt + 2'h1;
              fl_start <= 1'b1;
              fl_count <= {1'b0, press_cnt + 2'h1};
              if (press_cnt + 2'h1 == FOB_HOLDS)
              begin
                menu_sel <= period_sel;
                menu_shown <= 1'b0;
                cfg <= CFG_MENU;
              end
            end
            else
              hold_cnt <= hold_cnt + 32'h1;
          end
        end
        CFG_MENU:
        begin
          if (key_edge && !key_switch)
          begin
            store_sel <= 1'b1;
            cfg <= CFG_IDLE;
          end
          else if (left_rise)
          begin
            menu_shown <= 1'b1;
            fl_start <= 1'b1;
            if (!menu_shown)
              fl_count <= {1'b0, menu_sel} + 3'h1;
            else
            begin
              // The two-bit selection rolls from infinite to 10 days.
              menu_sel <= menu_sel + 2'h1;
              fl_count <= {1'b0, menu_sel + 2'h1} + 3'h1;
            end
          end
        end
        default: cfg <= CFG_IDLE;
      endcase
    end
  end

  // The selection lives in flip-flops that only power-on reset clears.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      period_sel <= PER_RESET;
    else if (store_sel)
      period_sel <= menu_sel;
    else if (wr_config)
      period_sel <= hwdata[1:0];
  end

  // ==========================================================================
  // Flasher, lamp and enables
  logic fl_out;

  ssm_flasher #(
    .HALF_CYC(FLASH_CYCLES)
  ) u_flasher (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(fl_start),
    .count(fl_count),
    .flash(fl_out),
    .busy()
  );

  logic [31:0] lamp_cnt;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lamp_cnt <= 32'h0;
      security_lamp <= 1'b0;
      turn_flash <= 1'b0;
      receiver_en <= 1'b1;
      starter_en <= 1'b0;
      engine_controller_en <= 1'b0;
    end
    else
    begin
      turn_flash <= fl_out || alarm;
      receiver_en <= !storage;
      starter_en <= !storage && !armed;
      engine_controller_en <= !storage && !armed;
      // Flashing the lamp in storage would drain the battery.
      if (!armed || storage)
      begin
        lamp_cnt <= 32'h0;
        security_lamp <= 1'b0;
      end
      else if (lamp_cnt == LAMP_CYCLES - 32'h1)
      begin
        lamp_cnt <= 32'h0;
        security_lamp <= !security_lamp;
      end
      else
        lamp_cnt <= lamp_cnt + 32'h1;
    end
  end

  assign irq_set = {store_sel, (wake || intrusion) && armed && !alarm,
    wake, enter_storage};

endmodule : ssm_ctrl

// file: test/ssm_ctrl_chk.sv
// Port-level assertions for the storage-mode controller.
`timescale 1ns/1ps
module ssm_ctrl_chk #(
  parameter longint unsigned DAY_CYCLES = 64'd200
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Inputs watched
  input wire logic [1:0] htrans,
  input wire logic key_switch,
  input wire logic fob_button,
  // Vehicle outputs
  input wire logic alarm,
  input wire logic receiver_en,
  input wire logic starter_en,
  input wire logic engine_controller_en,
  input wire logic security_lamp
);
  // The day timer restarts together with the day count on a key edge,
  // so even the shortest period needs ten whole idle days.
  localparam longint unsigned MIN_IDLE = 10 * DAY_CYCLES;
  logic key_q;
  logic [31:0] idle_cnt;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_q <= 1'b0;
      idle_cnt <= 32'h0;
    end
    else
    begin
      key_q <= key_switch;
      if (key_switch != key_q)
        idle_cnt <= 32'h0;
      else if (idle_cnt != 32'hffffffff)
        idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // ==========================================================================
  // Storage entry and wake
  sequence s_wake;
    !receiver_en ##1 receiver_en;
  endsequence
  sequence s_deep;
    !receiver_en && !$past(receiver_en) && !$past(receiver_en, 2);
  endsequence

  AST_NO_EARLY: assert property (
    $fell(receiver_en) |-> {32'h0, idle_cnt} >= MIN_IDLE)
    else $error("storage entered too soon after key activity");
  AST_IMMOBILE: assert property (
    !receiver_en |-> !starter_en && !engine_controller_en)
    else $error("vehicle enabled while in storage");
  AST_DEEP_LAMP: assert property (
    s_deep |-> $stable(security_lamp))
    else $error("security lamp moved in storage");
  AST_KEEP_ASLEEP: assert property (
    !receiver_en && !key_switch |=> !receiver_en)
    else $error("storage left without key on");
  AST_WAKE_SOON: assert property (
    !receiver_en && $rose(key_switch) |-> ##[1:4] receiver_en)
    else $error("no wake after key on");
  AST_WAKE_ALARM: assert property (
    s_wake ##0 !starter_en |-> ##[0:2] alarm)
    else $error("armed wake without alarm");
  AST_ALARM_HOLDS: assert property (
    alarm && !fob_button && !$past(fob_button) && !$past(fob_button, 2)
    && htrans == 2'h0 && $past(htrans) == 2'h0 |=> alarm)
    else $error("alarm dropped without disarm");
  AST_DEAF_FOB: assert property (
    !receiver_en && key_switch == $past(key_switch, 2) && alarm
    && htrans == 2'h0 && $past(htrans) == 2'h0 |=> alarm)
    else $error("alarm cleared while in storage");
endmodule : ssm_ctrl_chk

// file: test/ssm_rider.sv
// Behavioural rider: key switch, stop switch, left turn switch and fob.
`timescale 1ns/1ps
module ssm_rider #(
  parameter int HOLD = 20
) (
  // Clock
  input wire logic hclk,
  // Rider controls
  output logic key_switch,
  output logic stop_switch_off,
  output logic left_turn,
  output logic fob_button,
  output logic intrusion
);
  initial
  begin
    key_switch = 1'b0;
    stop_switch_off = 1'b1;
    left_turn = 1'b0;
    fob_button = 1'b0;
    intrusion = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle

  task automatic key(input logic v);
    @(posedge hclk);
    key_switch <= v;
    idle(10);
  endtask : key

  task automatic left();
    @(posedge hclk);
    left_turn <= 1'b1;
    idle(3);
    left_turn <= 1'b0;
    idle(3);
  endtask : left

  // Held past the confirm time, then released before the next hold.
  task automatic fob_hold();
    @(posedge hclk);
    fob_button <= 1'b1;
    idle(HOLD + 5);
    fob_button <= 1'b0;
    idle(3);
  endtask : fob_hold

  task automatic tap2(input int gap);
    @(posedge hclk);
    fob_button <= 1'b1;
    idle(3);
    fob_button <= 1'b0;
    idle(gap);
    fob_button <= 1'b1;
    idle(3);
    fob_button <= 1'b0;
    idle(5);
  endtask : tap2

  task automatic poke();
    @(posedge hclk);
    intrusion <= 1'b1;
    idle(3);
    intrusion <= 1'b0;
  endtask : poke

  task automatic stop(input logic v);
    @(posedge hclk);
    stop_switch_off <= v;
  endtask : stop

  // Key off first so the on-off-on-off-on pattern starts on a clean edge.
  task automatic entry();
    key(1'b0);
    for (int i = 0; i < 5; i++)
      key(i % 2 == 0);
    left();
    left();
  endtask : entry
endmodule : ssm_rider

// file: test/ssm_ctrl_tb.sv
// Self-checking bench for the storage-mode controller.
`timescale 1ns/1ps
module ssm_ctrl_tb;
  import ssm_pkg::*;
  localparam int DAY = 200;
  typedef struct {
    logic [1:0] per;
    int days;
    logic store;
  } ssm_row_t;
  ssm_row_t rows [4] = '{'{PER_10, 10, 1'b1}, '{PER_20, 20, 1'b1},
    '{PER_60, 60, 1'b1}, '{PER_INF, 70, 1'b0}};
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, flash_q;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic key_switch, stop_switch_off, left_turn, fob_button, intrusion;
  logic turn_flash, security_lamp, alarm, receiver_en;
  logic starter_en, engine_controller_en;
  int fail_count, n_checks, flashes, cycles;

  ssm_ctrl #(.DAY_CYCLES(DAY), .WINDOW_CYCLES(50), .HOLD_CYCLES(20),
    .FLASH_CYCLES(4), .LAMP_CYCLES(8)) u_dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .key_switch(key_switch), .stop_switch_off(stop_switch_off),
    .left_turn(left_turn), .fob_button(fob_button),
    .intrusion(intrusion), .turn_flash(turn_flash),
    .security_lamp(security_lamp), .alarm(alarm),
    .receiver_en(receiver_en), .starter_en(starter_en),
    .engine_controller_en(engine_controller_en));
  ssm_rider #(.HOLD(20)) u_rider (.hclk(hclk), .key_switch(key_switch),
    .stop_switch_off(stop_switch_off), .left_turn(left_turn),
    .fob_button(fob_button), .intrusion(intrusion));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Counts confirmation flashes and cuts a hang short.
  always @(posedge hclk)
  begin
    flash_q <= turn_flash;
    if (turn_flash && !flash_q)
      flashes++;
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ_BIT;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  initial
  begin
    {hresetn, hsel, hwrite, flash_q} = 4'h0;
    {haddr, htrans, hwdata} = 42'h0;
    hsize = 3'h0;
    {fail_count, n_checks, flashes, cycles} = 128'h0;
    repeat (2) @(posedge hclk);
    chk("rx_rst", 32'h1, receiver_en);
    chk("alarm_rst", 32'h0, alarm);
    hresetn <= 1'b1;
    rdchk("status", REG_STATUS, 32'h10);
    chk("okay", 32'h0, hresp);
    rdchk("unmapped", 8'h14, 32'h0);
    bus(8'h14, 1'b1, 32'hffffffff);
    rdchk("unmapped_wr", 8'h14, 32'h0);
    u_rider.entry();
    settle(45);
    chk("fresh_flash", 32'h0, flashes);
    u_rider.stop(1'b0);
    u_rider.entry();
    u_rider.stop(1'b1);
    settle(45);
    chk("stop_on", 32'h0, flashes);
    flashes = 0;
    u_rider.entry();
    settle(45);
    chk("entry_flash", 32'h2, flashes);
    for (int i = 1; i <= 3; i++)
    begin
      flashes = 0;
      u_rider.fob_hold();
      settle(45);
      chk("hold_flash", i, flashes);
    end
    for (int i = 0; i < 6; i++)
    begin
      flashes = 0;
      u_rider.left();
      settle(45);
      chk("menu_flash", i % 4 + 1, flashes);
    end
    u_rider.key(1'b0);
    rdchk("stored", REG_CONFIG, {30'h0, PER_20});
    bus(REG_IRQ_MASK, 1'b1, 32'h0);
    foreach (rows[r])
    begin
      bus(REG_CONFIG, 1'b1, {30'h0, rows[r].per});
      u_rider.key(1'b1);
      u_rider.key(1'b0);
      settle((rows[r].days - 1) * DAY - 30);
      chk("early", 32'h1, receiver_en);
      settle(DAY + 60);
      chk("asleep", {31'h0, !rows[r].store}, receiver_en);
      chk("starter", {31'h0, !rows[r].store}, starter_en);
      chk("eng", {31'h0, !rows[r].store}, engine_controller_en);
      if (rows[r].store)
      begin
        chk("irq_masked", 32'h0, irq);
        bus(REG_IRQ_MASK, 1'b1, 32'h1);
        settle(3);
        chk("irq_on", 32'h1, irq);
        bus(REG_IRQ_STAT, 1'b1, 32'h1);
        settle(3);
        chk("irq_clear", 32'h0, irq);
        bus(REG_IRQ_MASK, 1'b1, 32'h0);
        u_rider.key(1'b1);
        settle(2);
        chk("awake", 32'h1, receiver_en);
        chk("quiet_wake", 32'h0, alarm);
      end
    end
    u_rider.key(1'b1);
    u_rider.key(1'b0);
    bus(REG_CONFIG, 1'b1, 32'h0);
    bus(REG_CMD, 1'b1, 32'h1);
    settle(4);
    rd = {31'h0, !security_lamp};
    settle(8);
    chk("lamp_blink", rd, security_lamp);
    settle(10 * DAY + 28);
    chk("armed_store", 32'h0, receiver_en);
    chk("lamp_off", 32'h0, security_lamp);
    u_rider.tap2(10);
    u_rider.poke();
    settle(3);
    chk("store_alarm", 32'h1, alarm);
    bus(REG_CMD, 1'b1, 32'h2);
    bus(REG_CMD, 1'b1, 32'h1);
    chk("code_disarm", 32'h0, alarm);
    u_rider.tap2(10);
    rdchk("deaf", REG_STATUS, 32'h0a03);
    u_rider.key(1'b1);
    settle(2);
    chk("still_armed", 32'h0, starter_en);
    chk("wake_alarm", 32'h1, alarm);
    u_rider.tap2(60);
    settle(100);
    chk("slow_tap", 32'h1, alarm);
    u_rider.tap2(10);
    settle(5);
    chk("disarm", 32'h0, alarm);
    chk("unlock", 32'h1, starter_en);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_rx", 32'h1, receiver_en);
    hresetn <= 1'b1;
    rdchk("refresh", REG_STATUS, 32'h10);
    summarize();
  end
endmodule : ssm_ctrl_tb

bind ssm_ctrl ssm_ctrl_chk #(.DAY_CYCLES(DAY_CYCLES)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .htrans(htrans), .key_switch(key_switch),
  .fob_button(fob_button), .alarm(alarm), .receiver_en(receiver_en),
  .starter_en(starter_en), .engine_controller_en(engine_controller_en),
  .security_lamp(security_lamp));
